// ---- inc/spm_regs.vh ----
// Purpose: Constants for the serial port block (shift mode and 8-bit async mode)
// Assumes: Included by bare name from every design file
// Notes: One CPU clock per machine state, six states per machine cycle
//
// Operation
// - Mode 0 moves 8 bits LSB first on data pin, clock on clock pin
// - Mode 0 bit rate is fixed at CPU clock over six
// - Mode 0 buffer write loads marker, transmit-active rises a machine cycle later
// - Mode 0 transmit clock low in states 3-5, high in 6, 1, 2
// - Mode 0 transmit shifts right at state 6 with zeros entering
// - Mode 0 last shift, then stop and flag at state 1 of cycle ten
// - Mode 0 receive starts on enable and clear flag; preload pattern at state 6
// - Mode 0 receive clock toggles at states 3 and 6; shift-in sampled at 5
// - Mode 0 receive ends when preload zero leaves; buffer loaded, flag set
// - Mode 1 frame is start zero, 8 data LSB first, stop one into ninth field
// - Mode 1 rate comes from timer overflow and doubling bit, reset zero
// - Mode 1 buffer write loads marker; start follows next divide-by-16 rollover
// - Mode 1 start bit, then data one bit later, first shift a bit after
// - Mode 1 last shift drops transmit-active, sets done at tenth rollover
// - Mode 1 falling edge on input clears divider and fills receive register
// - Mode 1 samples at counter states 7, 8, 9; majority wins
// - Nonzero first bit time aborts reception and resumes edge hunting
// - Mode 1 completion loads buffer only if flag clear and filter allows
// - Failed completion discards frame; always return to edge hunting
// - Auto-reload rate is clock/192 or /96, over 256 minus reload
// - Transmit-done set by hardware at end of data, cleared only by software
`ifndef SPM_REGS_VH
`define SPM_REGS_VH
// Register byte offsets
`define SPM_OFS_BUFFER 8'h00
`define SPM_OFS_CONTROL 8'h04
`define SPM_OFS_POWER 8'h08
`define SPM_OFS_RELOAD 8'h0C
`define SPM_OFS_STATUS 8'h10
// Control register fields, and the power register doubling bit
`define SPM_CTL_RXDONE 0
`define SPM_CTL_TXDONE 1
`define SPM_CTL_NINTH 2
`define SPM_CTL_RXEN 4
`define SPM_CTL_FILTER 5
`define SPM_CTL_MODE1 6
`define SPM_PWR_DOUBLE 7
// Reset values
`define SPM_RST_CONTROL 8'h00
`define SPM_RST_DOUBLE 1'b0
`define SPM_RST_RELOAD 8'h00
// Timing counts
`define SPM_STATE_LAST 3'h5
`define SPM_STATE_S3 3'h2
`define SPM_STATE_S5 3'h4
// Mode 0 receive clock moves a state early, the pin flop adds one
`define SPM_RXCLK_FALL 3'h0
`define SPM_RXCLK_RISE 3'h3
`define SPM_DIV_LAST 4'hF
`define SPM_SAMPLE_A 4'h7
`define SPM_SAMPLE_B 4'h8
`define SPM_SAMPLE_C 4'h9
`define SPM_M0_PRELOAD 8'hFE
`define SPM_M1_PRELOAD 9'h1FF
`endif

// ---- rtl/spm_baud.v ----
// Purpose: Machine-state sequencer, timer reload divider and shared divide-by-16
// Assumes: Reload value and doubling bit come from software registers
// Notes: Sixteenth ticks are timer overflows, halved unless doubling is set
`timescale 1ns/1ps
`include "spm_regs.vh"
module spm_baud (
    input wire clock_i, // CPU clock
    input wire rst_i, // Synchronous reset
    input wire [7:0] reload_i, // Timer reload value
    input wire double_i, // Rate doubling
    input wire div_clear_i, // Realign divide-by-16
    output reg [2:0] mstate_o, // Machine state 0..5 is S1..S6
    output wire tick16_o, // One sixteenth of a bit time
    output reg [3:0] div_o, // Divide-by-16 count
    output wire rollover_o // Bit boundary pulse
);
    reg [7:0] tcount;
    reg half;
    wire overflow;
    assign overflow = (mstate_o == `SPM_STATE_LAST) && (tcount == 8'hFF);
    assign tick16_o = overflow && (double_i || half);
    assign rollover_o = tick16_o && (div_o == `SPM_DIV_LAST);
    ////////////////////////////////////////////////////////////////////////
    // Machine states, timer and divider
    always @(posedge clock_i) begin
        if (rst_i) begin
            mstate_o <= 3'h0;
            tcount <= 8'h00;
            half <= 1'b0;
            div_o <= 4'h0;
        end else begin
            mstate_o <= (mstate_o == `SPM_STATE_LAST) ? 3'h0 : mstate_o + 3'h1;
            if (mstate_o == `SPM_STATE_LAST) begin
                tcount <= overflow ? reload_i : tcount + 8'h01;
            end
            if (overflow) begin
                half <= ~half;
            end
            if (div_clear_i) begin
                div_o <= 4'h0;
            end else if (tick16_o) begin
                div_o <= div_o + 4'h1;
            end
        end
    end
endmodule

// ---- rtl/spm_rx1.v ----
// Purpose: Mode 1 receiver with start detection and three-sample majority
// Assumes: Shared divide-by-16 is cleared through div_clear_o
// Notes: Frame result is offered as a one-cycle load pulse
`timescale 1ns/1ps
`include "spm_regs.vh"
module spm_rx1 (
    input wire clock_i, // CPU clock
    input wire rst_i, // Synchronous reset
    input wire enable_i, // Mode 1 with receive enabled
    input wire rxd_i, // Serial input
    input wire tick16_i, // Sixteenth tick
    input wire [3:0] div_i, // Divide-by-16 count
    input wire done_flag_i, // Receive-done flag
    input wire filter_i, // Multiprocessor filter bit
    output wire div_clear_o, // Realign shared divider
    output reg load_o, // Load buffer pulse
    output reg [7:0] data_o, // Received byte
    output reg ninth_o, // Received stop bit
    output reg busy_o // Frame in progress
);
    reg [8:0] shreg;
    reg [2:0] samp;
    reg last_pin;
    reg first;
    function maj3;
        input [2:0] s;
        begin
            maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
        end
    endfunction
    function [7:0] rev8;
        input [7:0] v;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                rev8[i] = v[7 - i];
            end
        end
    endfunction
    assign div_clear_o = enable_i && !busy_o && tick16_i && last_pin && !rxd_i;
    ////////////////////////////////////////////////////////////////////////
    // Start hunt, sampling and shifting
    always @(posedge clock_i) begin
        if (rst_i) begin
            shreg <= 9'h000;
            samp <= 3'h0;
            last_pin <= 1'b1;
            first <= 1'b0;
            busy_o <= 1'b0;
            load_o <= 1'b0;
            data_o <= 8'h00;
            ninth_o <= 1'b0;
        end else begin
            load_o <= 1'b0;
            if (tick16_i) begin
                last_pin <= rxd_i;
            end
            if (!enable_i) begin
                busy_o <= 1'b0;
            end else if (div_clear_o) begin
                shreg <= `SPM_M1_PRELOAD;
                busy_o <= 1'b1;
                first <= 1'b1;
            end else if (busy_o && tick16_i) begin
                if (div_i == `SPM_SAMPLE_A) samp[0] <= rxd_i;
                if (div_i == `SPM_SAMPLE_B) samp[1] <= rxd_i;
                if (div_i == `SPM_SAMPLE_C) samp[2] <= rxd_i;
                if (div_i == `SPM_DIV_LAST) begin
                    first <= 1'b0;
                    if (first && maj3(samp)) begin
                        busy_o <= 1'b0;
                    end else begin
                        shreg <= {shreg[7:0], maj3(samp)};
                        if (!shreg[8]) begin
                            busy_o <= 1'b0;
                            if (!done_flag_i && (!filter_i || maj3(samp))) begin
                                load_o <= 1'b1;
                                data_o <= rev8(shreg[7:0]);
                                ninth_o <= maj3(samp);
                            end
                        end
                    end
                end
            end
        end
    end
endmodule

// ---- rtl/spm_top.v ----
// Purpose: Serial port in shift-register mode and 8-bit asynchronous mode, APB slave
// Assumes: Single clock; pins synchronous to it; zero-wait APB answers
// Notes: Data pin is two-way in mode 0; clock pin carries data in mode 1
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "spm_regs.vh"
module spm_top (
    input wire clock_i, // CPU clock, 40 MHz
    input wire rst_i, // Synchronous reset, active high
    input wire psel_i, // APB select
    input wire penable_i, // APB enable
    input wire pwrite_i, // APB direction
    input wire [7:0] paddr_i, // APB byte address
    input wire [31:0] pwdata_i, // APB write data
    output reg [31:0] prdata_o, // APB read data
    output wire pready_o, // APB ready
    output reg pslverr_o, // APB error on unmapped address
    input wire rxd_i, // Data pin level
    output reg rxd_o, // Data pin drive value
    output reg rxd_oe_o, // Data pin drive enable
    output reg txd_o // Shift clock in mode 0, serial out in mode 1
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam M0_IDLE = 2'h0;
    localparam M0_WAIT = 2'h1;
    localparam M0_RUN = 2'h2;
    localparam M0_END = 2'h3;
    reg [7:0] control;
    reg double_rate;
    reg [7:0] reload;
    reg [7:0] rx_buffer;
    reg [8:0] tsr;
    reg tx_req;
    reg tx_send;
    reg tx_data;
    reg [1:0] tx0_state;
    reg [1:0] rx0_state;
    reg [7:0] rsr;
    reg rx0_sample;
    reg rx0_clk;
    reg [31:0] next_rdata;
    reg next_err;
    wire [2:0] mstate;
    wire tick16;
    wire [3:0] div;
    wire rollover;
    wire div_clear;
    wire rx1_load;
    wire [7:0] rx1_data;
    wire rx1_ninth;
    wire rx1_busy;
    wire mode1;
    wire rx_en;
    wire s6;
    wire access;
    wire wr_buffer;
    wire wr_control;
    wire tx_set;
    wire rx_set;
    wire rx0_active;
    function [7:0] rev8;
        input [7:0] v;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                rev8[i] = v[7 - i];
            end
        end
    endfunction
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction
    assign mode1 = control[`SPM_CTL_MODE1];
    assign rx_en = control[`SPM_CTL_RXEN];
    assign s6 = (mstate == `SPM_STATE_LAST);
    assign rx0_active = (rx0_state == M0_RUN) || (rx0_state == M0_END);
    ////////////////////////////////////////////////////////////////////////
    // Shared timing and mode 1 receiver
    spm_baud i_spm_baud (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .reload_i(reload),
        .double_i(double_rate),
        .div_clear_i(div_clear),
        .mstate_o(mstate),
        .tick16_o(tick16),
        .div_o(div),
        .rollover_o(rollover)
    );
    spm_rx1 i_spm_rx1 (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(mode1 && rx_en),
        .rxd_i(rxd_i),
        .tick16_i(tick16),
        .div_i(div),
        .done_flag_i(control[`SPM_CTL_RXDONE]),
        .filter_i(control[`SPM_CTL_FILTER]),
        .div_clear_o(div_clear),
        .load_o(rx1_load),
        .data_o(rx1_data),
        .ninth_o(rx1_ninth),
        .busy_o(rx1_busy)
    );
    ////////////////////////////////////////////////////////////////////////
    // APB decode; writes take effect in the access cycle
    assign pready_o = 1'b1;
    assign access = psel_i && penable_i;
    assign wr_buffer = access && pwrite_i && hit(paddr_i, `SPM_OFS_BUFFER);
    assign wr_control = access && pwrite_i && hit(paddr_i, `SPM_OFS_CONTROL);
    // Read data mux, captured in the setup cycle
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr_i)
            `SPM_OFS_BUFFER: next_rdata[7:0] = rx_buffer;
            `SPM_OFS_CONTROL: next_rdata[7:0] = control;
            `SPM_OFS_POWER: next_rdata[`SPM_PWR_DOUBLE] = double_rate;
            `SPM_OFS_RELOAD: next_rdata[7:0] = reload;
            `SPM_OFS_STATUS: next_rdata[3:0] = {rx1_busy, rx0_active, tx_req, tx_send};
            default: next_err = 1'b1;
        endcase
    end
    always @(posedge clock_i) begin
        if (rst_i) begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
            pslverr_o <= next_err;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Software registers; hardware set wins over a software clear
    assign tx_set = mode1 ? (tx_send && rollover && (tsr[8:1] == 8'h01))
                          : (tx0_state == M0_END);
    assign rx_set = mode1 ? rx1_load : (rx0_state == M0_END);
    always @(posedge clock_i) begin
        if (rst_i) begin
            control <= `SPM_RST_CONTROL;
            double_rate <= `SPM_RST_DOUBLE;
            reload <= `SPM_RST_RELOAD;
        end else begin
            if (wr_control) begin
                control <= pwdata_i[7:0];
            end
            if (access && pwrite_i && hit(paddr_i, `SPM_OFS_POWER)) begin
                double_rate <= pwdata_i[`SPM_PWR_DOUBLE];
            end
            if (access && pwrite_i && hit(paddr_i, `SPM_OFS_RELOAD)) begin
                reload <= pwdata_i[7:0];
            end
            if (tx_set) begin
                control[`SPM_CTL_TXDONE] <= 1'b1;
            end
            if (rx_set) begin
                control[`SPM_CTL_RXDONE] <= 1'b1;
            end
            if (rx1_load) begin
                control[`SPM_CTL_NINTH] <= rx1_ninth;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Transmitter: shared shift register for both modes
    always @(posedge clock_i) begin
        if (rst_i) begin
            tsr <= 9'h000;
            tx_req <= 1'b0;
            tx_send <= 1'b0;
            tx_data <= 1'b0;
            tx0_state <= M0_IDLE;
        end else if (mode1) begin
            tx0_state <= M0_IDLE;
            if (wr_buffer && !tx_req && !tx_send) begin
                tsr <= {1'b1, pwdata_i[7:0]};
                tx_req <= 1'b1;
            end else if (rollover) begin
                if (tx_req) begin
                    tx_req <= 1'b0;
                    tx_send <= 1'b1;
                    tx_data <= 1'b0;
                end else if (tx_send && !tx_data) begin
                    tx_data <= 1'b1;
                end else if (tx_send) begin
                    tsr <= {1'b0, tsr[8:1]};
                    if (tsr[8:1] == 8'h01) begin
                        tx_send <= 1'b0;
                        tx_data <= 1'b0;
                    end
                end
            end
        end else begin
            tx_data <= 1'b0;
            case (tx0_state)
                M0_IDLE: begin
                    if (wr_buffer) begin
                        tsr <= {1'b1, pwdata_i[7:0]};
                        tx_req <= 1'b1;
                    end else if (tx_req && s6) begin
                        tx_req <= 1'b0;
                        tx0_state <= M0_WAIT;
                    end
                end
                M0_WAIT: begin
                    if (s6) begin
                        tx_send <= 1'b1;
                        tx0_state <= M0_RUN;
                    end
                end
                M0_RUN: begin
                    if (s6) begin
                        tsr <= {1'b0, tsr[8:1]};
                        if (tsr[8:1] == 8'h01) begin
                            tx0_state <= M0_END;
                        end
                    end
                end
                M0_END: begin
                    tx_send <= 1'b0;
                    tx0_state <= M0_IDLE;
                end
                default: begin
                    tx0_state <= M0_IDLE;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Mode 0 receiver
    always @(posedge clock_i) begin
        if (rst_i) begin
            rx0_state <= M0_IDLE;
            rsr <= 8'h00;
            rx0_sample <= 1'b0;
            rx0_clk <= 1'b1;
        end else if (mode1 || !rx_en) begin
            rx0_state <= M0_IDLE;
            rx0_clk <= 1'b1;
        end else begin
            case (rx0_state)
                M0_IDLE: begin
                    if (!control[`SPM_CTL_RXDONE] && !tx_send && !wr_control) begin
                        rx0_state <= M0_WAIT;
                    end
                end
                M0_WAIT: begin
                    if (s6) begin
                        rsr <= `SPM_M0_PRELOAD;
                        rx0_state <= M0_RUN;
                    end
                end
                M0_RUN: begin
                    if (mstate == `SPM_RXCLK_FALL) begin
                        rx0_clk <= 1'b0;
                    end
                    if (mstate == `SPM_RXCLK_RISE) begin
                        rx0_clk <= 1'b1;
                    end
                    if (mstate == `SPM_STATE_S5) begin
                        rx0_sample <= rxd_i;
                    end
                    if (s6) begin
                        rsr <= {rsr[6:0], rx0_sample};
                        if (!rsr[7]) begin
                            rx0_state <= M0_END;
                        end
                    end
                end
                M0_END: begin
                    rx0_state <= M0_IDLE;
                end
                default: begin
                    rx0_state <= M0_IDLE;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Receive buffer
    always @(posedge clock_i) begin
        if (rst_i) begin
            rx_buffer <= 8'h00;
        end else if (rx1_load) begin
            rx_buffer <= rx1_data;
        end else if (!mode1 && rx0_state == M0_END) begin
            rx_buffer <= rev8(rsr);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    always @(posedge clock_i) begin
        if (rst_i) begin
            txd_o <= 1'b1;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
        end else if (mode1) begin
            rxd_oe_o <= 1'b0;
            rxd_o <= 1'b1;
            txd_o <= !tx_send ? 1'b1 : (tx_data ? tsr[0] : 1'b0);
        end else begin
            rxd_oe_o <= tx_send;
            rxd_o <= tx_send ? tsr[0] : 1'b1;
            if (tx_send) begin
                txd_o <= !((mstate >= 3'h1) && (mstate <= 3'h3));
            end else begin
                txd_o <= rx0_active ? rx0_clk : 1'b1;
            end
        end
    end
endmodule

// ---- verification/spm_top_props.sv ----
// Purpose: Port checks for the serial port
// Assumes: Mode taken from control writes on APB
// Notes: Bound to spm_top below
`timescale 1ns/1ps
`include "spm_regs.vh"
module spm_top_props (
    input wire clock_i, // Clock
    input wire rst_i, // Reset
    input wire psel_i, // Select
    input wire penable_i, // Enable
    input wire pwrite_i, // Direction
    input wire [7:0] paddr_i, // Address
    input wire [31:0] pwdata_i, // Write data
    input wire [31:0] prdata_o, // Read data
    input wire pslverr_o, // Error
    input wire rxd_o, // Data drive
    input wire rxd_oe_o, // Data enable
    input wire txd_o // Clock or serial out
);
    logic m1;
    logic [3:0] nfall;
    wire acc = psel_i && penable_i;
    wire mapped = paddr_i inside {`SPM_OFS_BUFFER, `SPM_OFS_CONTROL, `SPM_OFS_POWER,
        `SPM_OFS_RELOAD, `SPM_OFS_STATUS};
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////////////
    // Mode bit, and clock falls counted while the data pin is driven
    always @(posedge clock_i) begin
        if (rst_i) m1 <= 1'b0;
        else if (acc && pwrite_i && paddr_i == `SPM_OFS_CONTROL) m1 <= pwdata_i[6];
        if (rst_i || !rxd_oe_o) nfall <= 4'h0;
        else if ($fell(txd_o)) nfall <= nfall + 4'h1;
    end
    // Bus answers and reset state
    unmapped_err_a: assert property (acc && !mapped |->
        pslverr_o && (pwrite_i || prdata_o == 32'h0)) else $error("unmapped not refused");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr_o && prdata_o[31:8] == 24'h0)
        else $error("mapped access bad");
    reset_idle_a: assert property ($fell(rst_i) |-> txd_o && rxd_o && !rxd_oe_o)
        else $error("pins not idle after reset");
    // Mode 0 clock and data
    clock_shape_a: assert property (!m1 && $fell(txd_o) |-> !txd_o [*3] ##1 txd_o [*3])
        else $error("mode 0 clock shape");
    data_hold_a: assert property (rxd_oe_o && !txd_o && !$past(txd_o) |-> $stable(rxd_o))
        else $error("data moved while clock low");
    bit_count_a: assert property ($fell(rxd_oe_o) |-> nfall == 4'h8)
        else $error("mode 0 frame not 8 clocks");
    // Mode 1 pins
    m1_no_drive_a: assert property (m1 |-> !rxd_oe_o)
        else $error("data pin driven in mode 1");
    m1_start_a: assert property (m1 && $fell(txd_o) |-> !txd_o [*8])
        else $error("mode 1 start bit short");
    // Main scenarios
    m0_tx_c: cover property ($rose(rxd_oe_o));
    m1_tx_c: cover property (m1 && $fell(txd_o));
    refused_c: cover property (acc && pslverr_o);
endmodule
bind spm_top spm_top_props i_spm_top_props (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
    .txd_o(txd_o));

// ---- verification/spm_far_end.sv ----
// Purpose: Far end: shift register in mode 0, remote UART in mode 1
// Assumes: Bench resolves the data pin and calls tasks right after an edge
// Notes: Mode 1 bit time is BT clocks
`timescale 1ns/1ps
module spm_far_end #(parameter int BT = 96) (
    input wire logic clock_i, // Clock
    input wire logic m1_i, // Async mode
    input wire logic sclk_i, // Device clock or serial out
    input wire logic data_i, // Data pin level
    input wire logic oe_i, // Device drives data pin
    output logic line_o // Model drive
);
    logic [7:0] got0 = 8'h00, src0 = 8'h00, got1 = 8'h00;
    logic cap = 1'b0, prev = 1'b1, stop1 = 1'b0, line = 1'b1;
    wire rise = sclk_i && !prev && !m1_i;
    assign line_o = m1_i ? line : src0[0];
    ////////////////////////////////////////////////////////////////////////////////////////
    // Mode 0: keep data seen while clock is low, shift on the rise
    always @(posedge clock_i) begin
        prev <= sclk_i;
        if (!sclk_i) cap <= data_i;
        if (rise && oe_i) got0 <= {cap, got0[7:1]};
        if (rise && !oe_i) src0 <= {~src0[0], src0[7:1]};
    end
    // Mode 1: take a frame from the device, sampling mid-bit
    initial forever begin
        do @(posedge clock_i); while (!(m1_i && !sclk_i));
        repeat (BT / 2) @(posedge clock_i);
        for (int i = 0; i < 9; i++) begin
            repeat (BT) @(posedge clock_i);
            {stop1, got1} = {sclk_i, stop1, got1[7:1]};
        end
    end
    // Mode 1: send a frame, or only a low pulse of n clocks when n is nonzero
    task automatic send1(input logic [7:0] d, input logic stop, input int n);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < (n > 0 ? 1 : 10); i++) begin
            line <= f[i];
            repeat (n > 0 ? n : BT) @(posedge clock_i);
        end
        line <= 1'b1;
        repeat (BT * 2) @(posedge clock_i);
    endtask
endmodule

// ---- verification/tb_serial_port_mode0_mode1.sv ----
// Purpose: Self-checking bench for the serial port, modes 0 and 1
// Assumes: Zero-wait APB; mode 1 at reload FF, doubled, 96 clocks a bit
// Notes: Far end model makes and captures serial traffic
`timescale 1ns/1ps
`include "spm_regs.vh"
module tb_serial_port_mode0_mode1;
    logic clock_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd_data;
    logic pready_o, pslverr_o, rxd_o, rxd_oe_o, txd_o, far_line, rd_err, m1 = 1'b0;
    wire rxd_i = rxd_oe_o ? rxd_o : far_line;
    int mismatches = 0, num_checks = 0, cycles = 0;
    spm_top i_spm_top (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i), .rxd_o(rxd_o),
        .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
    spm_far_end #(.BT(96)) i_spm_far_end (.clock_i(clock_i), .m1_i(m1), .sclk_i(txd_o),
        .data_i(rxd_i), .oe_i(rxd_oe_o), .line_o(far_line));
    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock and hang limit
    initial forever #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    // One APB transfer: setup, then access until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        @(posedge clock_i);
        while (pready_o !== 1'b1) @(posedge clock_i);
        rd_data = prdata_o;
        rd_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd_data);
    endtask
    // Poll the control register until a flag sets, bounded
    task automatic wait_flag(input int b);
        for (int k = 0; k < 2000 && rd_data[b] !== 1'b1; k++) apb(1'b0, `SPM_OFS_CONTROL, 32'h0);
    endtask
    // Counts and verdict
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(`SPM_OFS_CONTROL, 32'h0, "control");
        rd(`SPM_OFS_POWER, 32'h0, "double");
        rd(`SPM_OFS_RELOAD, 32'h0, "reload");
        rd(`SPM_OFS_STATUS, 32'h0, "status");
        rd(8'h14, 32'h0, "unmapped");
        chk("unmapped err", 32'h1, {31'h0, rd_err});
        $display("test reset done");
        apb(1'b1, `SPM_OFS_BUFFER, 32'hA5);
        wait (rxd_oe_o === 1'b1);
        apb(1'b1, `SPM_OFS_BUFFER, 32'h3C);
        wait_flag(`SPM_CTL_TXDONE);
        chk("m0 tx byte", 32'hA5, {24'h0, i_spm_far_end.got0});
        rd(`SPM_OFS_CONTROL, 32'h2, "ti held");
        apb(1'b1, `SPM_OFS_CONTROL, 32'h0);
        rd(`SPM_OFS_CONTROL, 32'h0, "ti cleared");
        $display("test mode 0 transmit done");
        i_spm_far_end.src0 <= 8'hC3;
        apb(1'b1, `SPM_OFS_CONTROL, 32'h10);
        wait_flag(`SPM_CTL_RXDONE);
        rd(`SPM_OFS_BUFFER, 32'hC3, "m0 rx byte");
        rd(`SPM_OFS_CONTROL, 32'h11, "m0 ri");
        $display("test mode 0 receive done");
        m1 <= 1'b1;
        apb(1'b1, `SPM_OFS_RELOAD, 32'hFF);
        apb(1'b1, `SPM_OFS_POWER, 32'h80);
        rd(`SPM_OFS_POWER, 32'h80, "double set");
        apb(1'b1, `SPM_OFS_CONTROL, 32'h50);
        apb(1'b1, `SPM_OFS_BUFFER, 32'h96);
        wait_flag(`SPM_CTL_TXDONE);
        repeat (96) @(posedge clock_i);
        chk("m1 tx", 32'h196, {23'h0, i_spm_far_end.stop1, i_spm_far_end.got1});
        $display("test mode 1 transmit done");
        apb(1'b1, `SPM_OFS_CONTROL, 32'h50);
        i_spm_far_end.send1(8'h3B, 1'b1, 0);
        rd(`SPM_OFS_BUFFER, 32'h3B, "m1 rx byte");
        rd(`SPM_OFS_CONTROL, 32'h55, "m1 ri ninth");
        i_spm_far_end.send1(8'h44, 1'b1, 0);
        rd(`SPM_OFS_BUFFER, 32'h3B, "drop on ri");
        apb(1'b1, `SPM_OFS_CONTROL, 32'h70);
        i_spm_far_end.send1(8'h27, 1'b0, 0);
        rd(`SPM_OFS_CONTROL, 32'h70, "drop on stop");
        i_spm_far_end.send1(8'h00, 1'b1, 20);
        i_spm_far_end.send1(8'hE1, 1'b1, 0);
        rd(`SPM_OFS_BUFFER, 32'hE1, "after glitch");
        rd(`SPM_OFS_CONTROL, 32'h75, "filter pass");
        $display("test mode 1 receive done");
        end_of_test();
    end
endmodule
